// ===== pmusc_pkg.sv
package pmusc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_LDO_A_CODE = 8'h90; // Level code, first regulator
  localparam logic [7:0] IDX_LDO_A_CTRL = 8'h91; // Control/status, first regulator
  localparam logic [7:0] IDX_LDO_B_CODE = 8'hA0; // Level code, second regulator
  localparam logic [7:0] IDX_LDO_B_CTRL = 8'hA1; // Control/status, second regulator
  localparam logic [7:0] IDX_AO_CTRL = 8'hB1; // Always-on regulator control
  localparam logic [7:0] IDX_SYS_CTRL = 8'hC0; // Button and watchdog control
  localparam logic [7:0] IDX_IRQ_SRC = 8'hC1; // Interrupt source address
  localparam logic [7:0] IDX_BTN_STAT = 8'hC2; // Button status
  localparam logic [7:0] IDX_GOFF = 8'hC3; // Global off and power cycle
  localparam logic [7:0] IDX_RST_CAUSE = 8'hC5; // Reset cause flags

  // ************************************************************
  // Interrupt source codes
  // ************************************************************
  localparam logic [7:0] SRC_LDO_A = 8'h90; // First regulator block
  localparam logic [7:0] SRC_LDO_B = 8'hA0; // Second regulator block
  localparam logic [7:0] SRC_SYS = 8'hC0; // System control block
  localparam logic [7:0] SRC_NONE = 8'hFF; // Nothing pending

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CODE_W = 6; // Width of level code
  localparam int BIT_EN = 7; // Regulator enable
  localparam int BIT_DCH = 2; // Discharge in shutdown
  localparam int BIT_FIRQ = 1; // Fault interrupt enable
  localparam int BIT_PG = 0; // Power good status
  localparam int BIT_PRESS_IE = 7; // Press interrupt enable
  localparam int BIT_REL_IE = 6; // Release interrupt enable
  localparam int BIT_WD_SR = 1; // Watchdog soft-reset enable
  localparam int BIT_WD_PC = 0; // Watchdog power-cycle enable
  localparam int BIT_PRESS_FLAG = 7; // Press flag
  localparam int BIT_REL_FLAG = 6; // Release flag
  localparam int BIT_BTN_LIVE = 5; // Live button level
  localparam int BIT_SD_REQ = 4; // Global shutdown request
  localparam int BIT_SD_ARM = 3; // Global shutdown arm
  localparam int BIT_SWPC = 0; // Software power cycle
  localparam int BIT_PC_FLAG = 1; // Power cycle occurred
  localparam int BIT_SR_FLAG = 0; // Soft reset occurred

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [5:0] RST_CODE = 6'h00; // Level code after reset
  localparam logic [7:0] RST_SRC = 8'hFF; // Source register after reset
  localparam int PC_DELAY_MS = 8; // Delay before software power cycle
  localparam int CLK_FREQ_MHZ = 100; // System clock rate
  localparam int PC_DELAY_CYCLES = PC_DELAY_MS * 1000 * CLK_FREQ_MHZ; // Delay in cycles
  localparam int PC_CNT_W = 20; // Delay counter width

  // Power cycle delay state
  typedef enum logic {
    PC_IDLE = 1'b0,
    PC_WAIT = 1'b1
  } pmusc_pc_e;

endpackage : pmusc_pkg

// ===== pmusc_regs.sv
// The APB register port was left to the implementer.
module pmusc_regs
  import pmusc_pkg::*;
#(
  parameter int PC_CYCLES = PC_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic push_button_input,
  input wire logic ldo_a_power_ok,
  input wire logic ldo_b_power_ok,
  input wire logic ldo_a_fault,
  input wire logic ldo_b_fault,
  input wire logic watchdog_expired,
  input wire logic sleep_entry,
  output logic [5:0] ldo_a_output_level_code,
  output logic ldo_a_enable,
  output logic ldo_a_discharge,
  output logic [5:0] ldo_b_output_level_code,
  output logic ldo_b_enable,
  output logic ldo_b_discharge,
  output logic always_on_ldo_enable,
  output logic irq_pending,
  output logic global_shutdown,
  output logic power_cycle_start,
  output logic soft_reset_start
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [4:0] sync1; // First synchroniser stage
    logic [4:0] sync2; // Second synchroniser stage
    logic btn_prev; // Button level last cycle
    logic [1:0] flt_prev; // Fault levels last cycle
    logic [5:0] a_code; // First regulator code
    logic a_en; // First regulator on
    logic a_dch; // First regulator discharge enable
    logic a_firq; // First regulator fault irq enable
    logic a_dch_act; // First regulator discharging
    logic [5:0] b_code; // Second regulator code
    logic b_en; // Second regulator on
    logic b_dch; // Second regulator discharge enable
    logic b_firq; // Second regulator fault irq enable
    logic b_dch_act; // Second regulator discharging
    logic ao_en; // Always-on regulator on
    logic press_ie; // Press interrupt enable
    logic rel_ie; // Release interrupt enable
    logic wd_sr_en; // Watchdog soft-reset enable
    logic wd_pc_en; // Watchdog power-cycle enable
    logic [7:0] src; // Interrupt source address
    logic press_flag; // Press interrupt seen
    logic rel_flag; // Release interrupt seen
    logic sd_arm; // Global shutdown armed
    logic sd_req; // Global shutdown request bit
    logic swpc; // Software power cycle pending
    logic pc_flag; // Power cycle happened
    logic sr_flag; // Soft reset happened
    pmusc_pc_e pc_st; // Delay state
    logic [PC_CNT_W-1:0] pc_cnt; // Delay counter
    logic irq; // Interrupt output
    logic sd_pulse; // Shutdown pulse
    logic pc_pulse; // Power cycle pulse
    logic sr_pulse; // Soft reset pulse
    logic rdy; // APB ready
    logic err; // APB error
    logic [31:0] rdata; // APB read data
  } pmusc_state_s;

  localparam logic [PC_CNT_W-1:0] PC_LAST = PC_CNT_W'(PC_CYCLES - 1); // Last count

  pmusc_state_s q; // Registered state
  pmusc_state_s d; // Next state
  logic [7:0] idx; // Register index
  logic acc; // Access completes this edge
  logic mapped; // Index decodes
  logic [7:0] rd; // Read value
  logic [7:0] wd; // Write value
  logic btn; // Synchronised button
  logic press_ev; // Press event
  logic rel_ev; // Release event
  logic flt_a_ev; // First regulator fault event
  logic flt_b_ev; // Second regulator fault event
  logic ev_any; // Any source event

  assign idx = paddr[9:2];
  assign wd = pwdata[7:0];
  assign acc = psel & penable & q.rdy;
  assign btn = q.sync2[0];
  assign press_ev = btn & ~q.btn_prev & q.press_ie;
  assign rel_ev = ~btn & q.btn_prev & q.rel_ie;
  assign flt_a_ev = q.sync2[3] & ~q.flt_prev[0] & q.a_firq;
  assign flt_b_ev = q.sync2[4] & ~q.flt_prev[1] & q.b_firq;
  assign ev_any = press_ev | rel_ev | flt_a_ev | flt_b_ev;

  // ************************************************************
  // Read decode
  // ************************************************************
  // Read mux, reserved bits zero
  always_comb begin
    rd = 8'h00;
    mapped = 1'b1;
    unique case (idx)
      IDX_LDO_A_CODE: rd = {2'b00, q.a_code};
      IDX_LDO_A_CTRL: rd = {q.a_en, 4'h0, q.a_dch, q.a_firq, q.sync2[1]};
      IDX_LDO_B_CODE: rd = {2'b00, q.b_code};
      IDX_LDO_B_CTRL: rd = {q.b_en, 4'h0, q.b_dch, q.b_firq, q.sync2[2]};
      IDX_AO_CTRL: rd = {q.ao_en, 7'h00};
      IDX_SYS_CTRL: rd = {q.press_ie, q.rel_ie, 4'h0, q.wd_sr_en, q.wd_pc_en};
      IDX_IRQ_SRC: rd = q.src;
      IDX_BTN_STAT: rd = {q.press_flag, q.rel_flag, btn, 5'h00};
      IDX_GOFF: rd = {3'b000, q.sd_req, q.sd_arm, 2'b00, q.swpc};
      IDX_RST_CAUSE: rd = {6'h00, q.pc_flag, q.sr_flag};
      default: mapped = 1'b0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  // Bus, writes, read side effects, then hardware events
  always_comb begin
    d = q;
    d.sync1 = {ldo_b_fault, ldo_a_fault, ldo_b_power_ok, ldo_a_power_ok, push_button_input};
    d.sync2 = q.sync1;
    d.btn_prev = btn;
    d.flt_prev = q.sync2[4:3];
    d.sd_pulse = 1'b0;
    d.pc_pulse = 1'b0;
    d.sr_pulse = 1'b0;
    // One wait state, then ready
    d.rdy = psel & penable & ~q.rdy;
    if (psel && penable && !q.rdy) begin
      d.rdata = {24'h000000, rd};
      d.err = ~mapped;
    end else begin
      d.rdata = 32'h00000000;
      d.err = 1'b0;
    end
    // Register writes
    if (acc && pwrite && mapped) begin
      unique case (idx)
        IDX_LDO_A_CODE: d.a_code = wd[CODE_W-1:0];
        IDX_LDO_A_CTRL: begin
          d.a_en = wd[BIT_EN];
          d.a_dch = wd[BIT_DCH];
          d.a_firq = wd[BIT_FIRQ];
        end
        IDX_LDO_B_CODE: d.b_code = wd[CODE_W-1:0];
        IDX_LDO_B_CTRL: begin
          d.b_en = wd[BIT_EN];
          d.b_dch = wd[BIT_DCH];
          d.b_firq = wd[BIT_FIRQ];
        end
        IDX_AO_CTRL: d.ao_en = wd[BIT_EN];
        IDX_SYS_CTRL: begin
          d.press_ie = wd[BIT_PRESS_IE];
          d.rel_ie = wd[BIT_REL_IE];
          d.wd_sr_en = wd[BIT_WD_SR];
          d.wd_pc_en = wd[BIT_WD_PC];
        end
        IDX_GOFF: begin
          // Request only acts when already armed
          if (wd[BIT_SD_REQ] && q.sd_arm) begin
            d.a_en = 1'b0;
            d.b_en = 1'b0;
            d.ao_en = 1'b0;
            d.sd_pulse = 1'b1;
            d.sd_arm = 1'b0;
            d.sd_req = 1'b0;
          end else begin
            d.sd_arm = wd[BIT_SD_ARM];
            d.sd_req = wd[BIT_SD_REQ];
          end
          // Start delay only from idle
          if (wd[BIT_SWPC] && q.pc_st == PC_IDLE) begin
            d.swpc = 1'b1;
            d.pc_st = PC_WAIT;
            d.pc_cnt = '0;
          end
        end
        default: ;
      endcase
    end
    // Clear on read
    if (acc && !pwrite) begin
      if (idx == IDX_IRQ_SRC) d.src = SRC_NONE;
      if (idx == IDX_BTN_STAT) begin
        d.press_flag = 1'b0;
        d.rel_flag = 1'b0;
      end
      if (idx == IDX_RST_CAUSE) begin
        d.pc_flag = 1'b0;
        d.sr_flag = 1'b0;
      end
    end
    // Events win over the read clear
    if (flt_a_ev) d.src = SRC_LDO_A;
    if (flt_b_ev) d.src = SRC_LDO_B;
    if (press_ev) begin
      d.press_flag = 1'b1;
      d.src = SRC_SYS;
    end
    if (rel_ev) begin
      d.rel_flag = 1'b1;
      d.src = SRC_SYS;
    end
    // Software power cycle delay
    if (q.pc_st == PC_WAIT) begin
      if (q.pc_cnt == PC_LAST) begin
        d.pc_st = PC_IDLE;
        d.swpc = 1'b0;
        d.pc_pulse = 1'b1;
        d.pc_flag = 1'b1;
      end else begin
        d.pc_cnt = q.pc_cnt + 1'b1;
      end
    end
    // Watchdog expiry
    if (watchdog_expired && q.wd_pc_en) begin
      d.pc_pulse = 1'b1;
      d.pc_flag = 1'b1;
    end
    if (watchdog_expired && q.wd_sr_en) begin
      d.sr_pulse = 1'b1;
      d.sr_flag = 1'b1;
    end
    // Sleep clears watchdog enables
    if (sleep_entry) begin
      d.wd_sr_en = 1'b0;
      d.wd_pc_en = 1'b0;
    end
    d.a_dch_act = ~d.a_en & d.a_dch;
    d.b_dch_act = ~d.b_en & d.b_dch;
    d.irq = (d.src != SRC_NONE) | d.press_flag | d.rel_flag;
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Synchronous reset to defined values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.a_code <= RST_CODE;
      q.b_code <= RST_CODE;
      q.src <= RST_SRC;
      q.pc_st <= PC_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign ldo_a_output_level_code = q.a_code;
  assign ldo_a_enable = q.a_en;
  assign ldo_a_discharge = q.a_dch_act;
  assign ldo_b_output_level_code = q.b_code;
  assign ldo_b_enable = q.b_en;
  assign ldo_b_discharge = q.b_dch_act;
  assign always_on_ldo_enable = q.ao_en;
  assign irq_pending = q.irq;
  assign global_shutdown = q.sd_pulse;
  assign power_cycle_start = q.pc_pulse;
  assign soft_reset_start = q.sr_pulse;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_pc_fire;
    q.pc_st == PC_WAIT && q.pc_cnt == PC_LAST;
  endsequence
  sequence s_pc_out;
    q.pc_pulse && q.pc_flag && q.pc_st == PC_IDLE;
  endsequence

  property p_ready_wait;
    @(posedge clk) disable iff (sys_rst) (psel && penable && !q.rdy) |=> q.rdy;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
  property p_src_read;
    @(posedge clk) disable iff (sys_rst)
      (acc && !pwrite && idx == IDX_IRQ_SRC && !ev_any) |=> q.src == SRC_NONE;
  endproperty
  a_src_read: assert property (p_src_read) else $error("source not reset by read");
  property p_press;
    @(posedge clk) disable iff (sys_rst)
      (btn && !q.btn_prev && q.press_ie) |=> (q.press_flag && q.src == SRC_SYS);
  endproperty
  a_press: assert property (p_press) else $error("press not flagged");
  property p_release;
    @(posedge clk) disable iff (sys_rst)
      (!btn && q.btn_prev && q.rel_ie) |=> (q.rel_flag && q.src == SRC_SYS);
  endproperty
  a_release: assert property (p_release) else $error("release not flagged");
  property p_sleep;
    @(posedge clk) disable iff (sys_rst) sleep_entry |=> (!q.wd_sr_en && !q.wd_pc_en);
  endproperty
  a_sleep: assert property (p_sleep) else $error("watchdog enables survive sleep");
  property p_shutdown;
    @(posedge clk) disable iff (sys_rst)
      (acc && pwrite && idx == IDX_GOFF && wd[BIT_SD_REQ] && q.sd_arm)
      |=> (q.sd_pulse && !q.a_en && !q.b_en && !q.ao_en);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("armed shutdown ignored");
  property p_noarm;
    @(posedge clk) disable iff (sys_rst) (q.sd_pulse) |-> $past(q.sd_arm);
  endproperty
  a_noarm: assert property (p_noarm) else $error("shutdown without arm");
  property p_wd_pc;
    @(posedge clk) disable iff (sys_rst)
      (watchdog_expired && q.wd_pc_en) |=> (q.pc_pulse && q.pc_flag);
  endproperty
  a_wd_pc: assert property (p_wd_pc) else $error("watchdog power cycle missing");
  property p_wd_sr;
    @(posedge clk) disable iff (sys_rst)
      (watchdog_expired && q.wd_sr_en) |=> (q.sr_pulse && q.sr_flag);
  endproperty
  a_wd_sr: assert property (p_wd_sr) else $error("watchdog soft reset missing");
  property p_pc_delay;
    @(posedge clk) disable iff (sys_rst) s_pc_fire |=> s_pc_out;
  endproperty
  a_pc_delay: assert property (p_pc_delay) else $error("delayed power cycle missing");
  property p_discharge;
    @(posedge clk) disable iff (sys_rst) q.a_dch_act == (!q.a_en && q.a_dch);
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge wrong");
  property p_live;
    @(posedge clk) disable iff (sys_rst)
      (psel && penable && !q.rdy && idx == IDX_BTN_STAT) |=> q.rdata[BIT_BTN_LIVE] == $past(btn);
  endproperty
  a_live: assert property (p_live) else $error("live button bit wrong");

endmodule : pmusc_regs

// ===== pmusc_tb_top.sv
module pmu_regulator_and_system_control_regs_tb_top
  import pmusc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals and bookkeeping
  // ************************************************************
  localparam int PCC = 20; // Shortened power cycle delay
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic btn = 1'b0; // Push button, 1 = asserted
  logic pok_a = 1'b0;
  logic pok_b = 1'b0;
  logic flt_a = 1'b0;
  logic flt_b = 1'b0;
  logic wd_exp = 1'b0;
  logic sleep = 1'b0;
  logic [5:0] code_a;
  logic [5:0] code_b;
  logic en_a;
  logic en_b;
  logic dch_a;
  logic dch_b;
  logic en_ao;
  logic irq;
  logic gsd;
  logic pcs;
  logic srs;
  int n_errors = 0;
  int checked = 0;
  int n_pc = 0; // Power cycle pulses seen
  int n_sr = 0; // Soft reset pulses seen
  int n_gs = 0; // Global shutdown pulses seen
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata}
  logic [32:0] msk_q[$]; // Bits that matter
  logic [32:0] mon_e;
  logic [32:0] mon_m;

  // Clock, 100 MHz
  always #5 clk = ~clk;

  pmusc_regs #(.PC_CYCLES(PCC)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .push_button_input(btn), .ldo_a_power_ok(pok_a), .ldo_b_power_ok(pok_b),
    .ldo_a_fault(flt_a), .ldo_b_fault(flt_b), .watchdog_expired(wd_exp),
    .sleep_entry(sleep), .ldo_a_output_level_code(code_a), .ldo_a_enable(en_a),
    .ldo_a_discharge(dch_a), .ldo_b_output_level_code(code_b), .ldo_b_enable(en_b),
    .ldo_b_discharge(dch_b), .always_on_ldo_enable(en_ao), .irq_pending(irq),
    .global_shutdown(gsd), .power_cycle_start(pcs), .soft_reset_start(srs)
  );

  // ************************************************************
  // Checking helpers
  // ************************************************************
  // Single compare point
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Response monitor, oldest note first
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      mon_e = exp_q.pop_front();
      mon_m = msk_q.pop_front();
      check("pslverr", 32'(pslverr & mon_m[32]), 32'(mon_e[32] & mon_m[32]));
      check("prdata", prdata & mon_m[31:0], mon_e[31:0] & mon_m[31:0]);
    end
  end

  // Pulse counters for the one-cycle outputs
  always @(posedge clk) begin
    if (pcs === 1'b1) n_pc <= n_pc + 1;
    if (srs === 1'b1) n_sr <= n_sr + 1;
    if (gsd === 1'b1) n_gs <= n_gs + 1;
  end

  // ************************************************************
  // Bus and stimulus tasks
  // ************************************************************
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [32:0] exp, input logic [32:0] msk);
    int n;
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'($urandom), wd}; // Upper bytes unused, so noise
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready wait", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Write, expecting no error
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0, {1'b1, 32'h0});
  endtask : wr

  // Read, expecting one byte and no error
  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b0, idx, 8'h00, {25'h0, d}, {33{1'b1}});
  endtask : rd

  // Let synchronisers and edge detectors catch up
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle

  // One-cycle watchdog expiry
  task automatic wd_pulse();
    @(posedge clk);
    wd_exp <= 1'b1;
    @(posedge clk);
    wd_exp <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : wd_pulse

  // Counts, then the verdict
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [7:0] idx_l[9];
    logic [7:0] code;
    idx_l = '{IDX_LDO_A_CODE, IDX_LDO_A_CTRL, IDX_LDO_B_CODE, IDX_LDO_B_CTRL, IDX_AO_CTRL,
              IDX_SYS_CTRL, IDX_BTN_STAT, IDX_GOFF, IDX_RST_CAUSE};
    void'($urandom(70));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values and refused access
    foreach (idx_l[i]) rd(idx_l[i], 8'h00);
    rd(IDX_IRQ_SRC, RST_SRC);
    apb(1'b0, 8'hFF, 8'h00, {1'b1, 32'h0}, {33{1'b1}});
    $display("Test reset_values done");
    // Level codes with reserved bits set
    for (int i = 0; i < 2; i++) begin
      code = 8'($urandom) | 8'hC0;
      wr(i ? IDX_LDO_B_CODE : IDX_LDO_A_CODE, code);
      rd(i ? IDX_LDO_B_CODE : IDX_LDO_A_CODE, code & 8'h3F);
      check("level code", 32'(i ? code_b : code_a), 32'(code[5:0]));
    end
    $display("Test level_codes done");
    // Control fields and power-good
    pok_a <= 1'b1;
    settle();
    wr(IDX_LDO_A_CTRL, 8'hFF);
    rd(IDX_LDO_A_CTRL, 8'h87);
    check("ldo a on, no discharge", 32'({en_a, dch_a}), 32'h2);
    wr(IDX_LDO_B_CTRL, 8'h04);
    rd(IDX_LDO_B_CTRL, 8'h04);
    check("ldo b off, discharge", 32'({en_b, dch_b}), 32'h1);
    wr(IDX_AO_CTRL, 8'hFF);
    rd(IDX_AO_CTRL, 8'h80);
    check("always on enable", 32'(en_ao), 32'h1);
    // Fault events, enabled on a, masked on b
    flt_a <= 1'b1;
    settle();
    check("irq after fault", 32'(irq), 32'h1);
    rd(IDX_IRQ_SRC, SRC_LDO_A);
    rd(IDX_IRQ_SRC, SRC_NONE);
    check("irq after source read", 32'(irq), 32'h0);
    flt_b <= 1'b1;
    settle();
    check("masked fault", 32'(irq), 32'h0);
    rd(IDX_IRQ_SRC, SRC_NONE);
    flt_a <= 1'b0;
    flt_b <= 1'b0;
    // Second regulator: power-good and an enabled fault
    pok_b <= 1'b1;
    settle();
    wr(IDX_LDO_B_CTRL, 8'h06);
    rd(IDX_LDO_B_CTRL, 8'h07);
    flt_b <= 1'b1;
    settle();
    check("irq after fault b", 32'(irq), 32'h1);
    rd(IDX_IRQ_SRC, SRC_LDO_B);
    flt_b <= 1'b0;
    $display("Test regulator_control done");
    // Button press and release, enabled then disabled
    wr(IDX_SYS_CTRL, 8'hC0);
    btn <= 1'b1;
    settle();
    check("irq on press", 32'(irq), 32'h1);
    rd(IDX_BTN_STAT, 8'hA0);
    rd(IDX_IRQ_SRC, SRC_SYS);
    btn <= 1'b0;
    settle();
    rd(IDX_BTN_STAT, 8'h40);
    rd(IDX_IRQ_SRC, SRC_SYS);
    wr(IDX_SYS_CTRL, 8'h00);
    btn <= 1'b1;
    settle();
    rd(IDX_BTN_STAT, 8'h20);
    btn <= 1'b0;
    settle();
    rd(IDX_BTN_STAT, 8'h00);
    rd(IDX_IRQ_SRC, SRC_NONE);
    $display("Test push_button done");
    // Watchdog actions, flags, sleep clearing
    wr(IDX_SYS_CTRL, 8'h3F);
    rd(IDX_SYS_CTRL, 8'h03);
    wd_pulse();
    check("watchdog power cycle", 32'(n_pc), 32'h1);
    check("watchdog soft reset", 32'(n_sr), 32'h1);
    rd(IDX_RST_CAUSE, 8'h03);
    rd(IDX_RST_CAUSE, 8'h00);
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    rd(IDX_SYS_CTRL, 8'h00);
    wd_pulse();
    check("no action after sleep", 32'(n_pc + n_sr), 32'h2);
    $display("Test watchdog done");
    // Global shutdown: request alone, then arm and request
    wr(IDX_LDO_B_CTRL, 8'h80);
    wr(IDX_GOFF, 8'h10);
    rd(IDX_GOFF, 8'h10);
    check("no shutdown unarmed", 32'({en_a, en_b, en_ao, 5'(n_gs)}), 32'hE0);
    wr(IDX_GOFF, 8'h08);
    wr(IDX_GOFF, 8'h18);
    repeat (2) @(posedge clk);
    check("shutdown", 32'({en_a, en_b, en_ao, 5'(n_gs)}), 32'h01);
    check("discharge when off", 32'(dch_a), 32'h1);
    rd(IDX_GOFF, 8'h00);
    $display("Test global_shutdown done");
    // Software power cycle after the delay
    wr(IDX_GOFF, 8'h01);
    repeat (PCC - 4) @(posedge clk);
    check("power cycle early", 32'(n_pc), 32'h1);
    repeat (10) @(posedge clk);
    check("power cycle late", 32'(n_pc), 32'h2);
    rd(IDX_RST_CAUSE, 8'h02);
    rd(IDX_GOFF, 8'h00);
    $display("Test software_power_cycle done");
    close_out();
  end

endmodule : pmu_regulator_and_system_control_regs_tb_top
